// ==== verification/oled_parallel_host_port_tb_top.sv ====
// Testbench: host port driving the display end over the 8080 bus
`timescale 1ns/1ps
module oled_parallel_host_port_tb_top
  import oled_port_pkg::*;
;
  localparam int PULSE = 6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [7:0] rdData;
  logic [7:0] readByte = 8'h00;
  logic cmdValid;
  logic pixValid;
  logic initActive;
  logic [7:0] cmdByte;
  logic [7:0] pixByte;
  logic [8:0] rxQ[$];
  int err_count = 0;
  int checks_done = 0;

  always #20 clk = ~clk;

  oled_bus_if bus ();
  oled_host_port #(.INIT_PULSE(PULSE)) i_oled_host_port (
    .clk(clk), .rst_n(rst_n), .clkEn(1'b1), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .bus(bus.host));
  oled_device_port i_oled_device_port (
    .clk(clk), .rst_n(rst_n), .clkEn(1'b1), .bus(bus.device),
    .cmdValid(cmdValid), .cmdByte(cmdByte), .pixValid(pixValid),
    .pixByte(pixByte), .readByte(readByte), .initActive(initActive));
  oled_port_checker i_checker (
    .clk(clk), .rst_n(rst_n), .csN(bus.csN), .rdN(bus.rdN),
    .wrN(bus.wrN), .dataCmd(bus.dataCmd), .chipInitN(bus.chipInitN),
    .interfaceModeSelA(bus.interfaceModeSelA),
    .interfaceModeSelB(bus.interfaceModeSelB), .hostByte(bus.hostByte),
    .hostByteOe(bus.hostByteOe), .devByteOe(bus.devByteOe),
    .cmdValid(cmdValid), .cmdByte(cmdByte), .pixValid(pixValid),
    .pixByte(pixByte), .initActive(initActive));

  // Collect every byte the display end delivers, tagged with its kind
  always @(posedge clk)
  begin
    if (cmdValid === 1'b1)
      rxQ.push_back({1'b0, cmdByte});
    if (pixValid === 1'b1)
      rxQ.push_back({1'b1, pixByte});
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 600 && rxQ.size() < n; i++)
    begin
      @(posedge clk);
      #1;
    end
    check(16'(rxQ.size()), 16'(n));
  endtask

  task automatic test_idle();
    logic [7:0] d;
    check({bus.csN, bus.rdN, bus.wrN, bus.chipInitN}, 4'hf);
    check({bus.interfaceModeSelA, bus.interfaceModeSelB}, 2'h3);
    check({bus.hostByteOe, bus.devByteOe}, 2'h0);
    check(initActive, 1'b0);
    reg_rd(ADDR_CMD, d);
    check(d, 8'h00);
    $display("idle test done");
  endtask

  task automatic test_init();
    logic [7:0] initCmd [INIT_LEN] = '{CMD_DISPLAY_OFF, CMD_SEG_REMAP,
      CMD_COM_SCAN, CMD_COM_PINS, CMD_COM_PINS_ARG, CMD_DISPLAY_ON};
    int n;
    logic [7:0] d;
    rxQ.delete();
    reg_wr(ADDR_CTRL, 8'h01 << CT_START_INIT);
    for (n = 0; n < 50 && bus.chipInitN !== 1'b0; n++)
      @(posedge clk);
    for (n = 0; n < 100 && bus.chipInitN === 1'b0; n++)
    begin
      @(posedge clk);
      #1;
    end
    check(16'(n), 16'(PULSE));
    wait_rx(INIT_LEN);
    for (n = 0; n < INIT_LEN; n++)
      check(rxQ[n], {1'b0, initCmd[n]});
    repeat (CYCLE_MIN_CYC) @(posedge clk);
    reg_rd(ADDR_STATUS, d);
    check({d[ST_INIT_DONE], d[ST_BUSY]}, 2'h2);
    $display("init test done");
  endtask

  task automatic test_xfer();
    logic [8:0] tx [4] = '{9'h03c, 9'h1c3, 9'h100, 9'h0ff};
    int i;
    rxQ.delete();
    for (i = 0; i < 4; i++)
    begin
      if (i == 2)
        wait_rx(2);
      reg_wr(tx[i][8] ? ADDR_DATA : ADDR_CMD, tx[i][7:0]);
    end
    wait_rx(4);
    for (i = 0; i < 4; i++)
      check(rxQ[i], tx[i]);
    $display("transfer test done");
  endtask

  task automatic test_full();
    logic [7:0] d;
    int i;
    rxQ.delete();
    // Let the previous transfer's gap run out so the port starts idle
    repeat (CYCLE_MIN_CYC) @(posedge clk);
    for (i = 0; i < 4; i++)
      reg_wr(ADDR_DATA, 8'h10 + i[7:0]);
    reg_rd(ADDR_STATUS, d);
    check(d[ST_FULL], 1'b1);
    repeat (120) @(posedge clk);
    check(16'(rxQ.size()), 16'd3);
    for (i = 0; i < rxQ.size(); i++)
      check(rxQ[i], 9'(9'h110 + i));
    reg_rd(ADDR_STATUS, d);
    check({d[ST_FULL], d[ST_BUSY]}, 2'h0);
    $display("buffer test done");
  endtask

  task automatic test_read();
    logic [7:0] d;
    int m;
    int n;
    for (m = 0; m < 2; m++)
    begin
      readByte <= m[0] ? 8'h5a : 8'ha5;
      reg_wr(ADDR_CTRL, (8'h01 << CT_READ) | (m[7:0] << CT_READ_DC));
      for (n = 0; n < 40 && bus.devByteOe !== 1'b1; n++)
        @(posedge clk);
      check(bus.parallelByteBus, m[0] ? 8'h5a : 8'ha5);
      repeat (20) @(posedge clk);
      reg_rd(ADDR_STATUS, d);
      check(d[ST_RDVALID], 1'b1);
      reg_rd(ADDR_DATA, d);
      check(d, m[0] ? 8'h5a : 8'ha5);
      reg_rd(ADDR_STATUS, d);
      check(d[ST_RDVALID], 1'b0);
    end
    $display("read test done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    test_idle();
    test_init();
    test_xfer();
    test_full();
    test_read();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    test_idle();
    stop_test();
  end
endmodule // oled_parallel_host_port_tb_top

// ==== verification/oled_port_checker.sv ====
// Assertions on the 8080 bus between the two port ends
`timescale 1ns/1ps
module oled_port_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic dataCmd,
  input wire logic chipInitN,
  input wire logic interfaceModeSelA,
  input wire logic interfaceModeSelB,
  input wire logic [7:0] hostByte,
  input wire logic hostByteOe,
  input wire logic devByteOe,
  // Device outputs
  input wire logic cmdValid,
  input wire logic [7:0] cmdByte,
  input wire logic pixValid,
  input wire logic [7:0] pixByte,
  input wire logic initActive
);
  logic wrNQ;
  logic lastDc;
  logic [7:0] lastByte;
  logic [3:0] wrAge;
  logic [3:0] rdAge;
  // Remember what the device ought to capture at each strobe rise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrNQ <= 1'b1;
      lastDc <= 1'b0;
      lastByte <= 8'h00;
      wrAge <= 4'hf;
      rdAge <= 4'hf;
    end
    else
    begin
      wrNQ <= wrN;
      if (wrN && !wrNQ && !csN)
      begin
        lastDc <= dataCmd;
        lastByte <= hostByte;
        wrAge <= 4'h0;
      end
      else if (wrAge != 4'hf)
        wrAge <= wrAge + 4'h1;
      if (!csN && !rdN)
        rdAge <= 4'h0;
      else if (rdAge != 4'hf)
        rdAge <= rdAge + 4'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_mode_sel;
    interfaceModeSelA && interfaceModeSelB;
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("mode selects not both high");
  property p_no_fight;
    !(devByteOe && hostByteOe);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the byte bus");
  property p_wr_selected;
    $fell(wrN) |-> !csN && rdN && hostByteOe;
  endproperty
  a_wr_selected: assert property (p_wr_selected)
    else $error("write strobe without select or drive");
  property p_rd_drive;
    devByteOe |-> rdAge <= 4'h5;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("device drives bus without a read");
  property p_cmd_capture;
    cmdValid |-> !lastDc && cmdByte == lastByte && wrAge <= 4'h6;
  endproperty
  a_cmd_capture: assert property (p_cmd_capture)
    else $error("command byte not the one written");
  property p_pix_capture;
    pixValid |-> lastDc && pixByte == lastByte && wrAge <= 4'h6;
  endproperty
  a_pix_capture: assert property (p_pix_capture)
    else $error("display byte not the one written");
  property p_init_enter;
    $fell(chipInitN) |-> ##[1:4] initActive;
  endproperty
  a_init_enter: assert property (p_init_enter)
    else $error("init input low but device not initializing");
  property p_init_quiet;
    !chipInitN [*3] |-> !cmdValid && !pixValid;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("byte delivered during init");
  property p_init_exit;
    $rose(chipInitN) |-> ##[1:5] !initActive;
  endproperty
  a_init_exit: assert property (p_init_exit)
    else $error("device stays in init after release");
endmodule // oled_port_checker

// ==== verilog/oled_bus_if.sv ====
// Parallel 8080-style bus between host and display end
`timescale 1ns/1ps
interface oled_bus_if;
  logic csN;
  logic rdN;
  logic wrN;
  logic dataCmd;
  logic chipInitN;
  logic interfaceModeSelA;
  logic interfaceModeSelB;
  logic [7:0] hostByte;
  logic hostByteOe;
  logic [7:0] devByte;
  logic devByteOe;
  // Resolved parallel_byte_bus level
  logic [7:0] parallelByteBus;
  assign parallelByteBus = devByteOe ? devByte :
                           (hostByteOe ? hostByte : 8'hff);
  modport host (
    output csN, rdN, wrN, dataCmd, chipInitN,
    output interfaceModeSelA, interfaceModeSelB,
    output hostByte, hostByteOe,
    input parallelByteBus
  );
  modport device (
    input csN, rdN, wrN, dataCmd, chipInitN,
    input interfaceModeSelA, interfaceModeSelB,
    output devByte, devByteOe,
    input parallelByteBus
  );
endinterface

// ==== verilog/oled_device_port.sv ====
// Display-side end of the 8080 parallel port
`timescale 1ns/1ps
module oled_device_port
  import oled_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Parallel bus
  oled_bus_if.device bus,
  // Captured bytes toward the panel logic
  output logic cmdValid,
  output logic [7:0] cmdByte,
  output logic pixValid,
  output logic [7:0] pixByte,
  // Read-back source and init state
  input wire logic [7:0] readByte,
  output logic initActive
);
  typedef struct packed {
    logic [1:0] csS;
    logic [1:0] wrS;
    logic [1:0] rdS;
    logic [1:0] dcS;
    logic [1:0] initS;
    logic [1:0][7:0] busS;
    logic wrPrev;
    logic cmdValid;
    logic [7:0] cmdByte;
    logic pixValid;
    logic [7:0] pixByte;
    logic [7:0] outByte;
    logic outOe;
    logic initActive;
  } dev_state_t;

  dev_state_t s_q, s_d;
  logic sel, wrLow, rdLow, wrRise;

  // Second stage of each synchroniser
  assign sel = !s_q.csS[1];
  assign wrLow = !s_q.wrS[1];
  assign rdLow = !s_q.rdS[1];
  assign wrRise = !s_q.wrPrev && !wrLow;

  always_comb
  begin
    s_d = s_q;
    if (clkEn)
    begin
      s_d.csS = {s_q.csS[0], bus.csN};
      s_d.wrS = {s_q.wrS[0], bus.wrN};
      s_d.rdS = {s_q.rdS[0], bus.rdN};
      s_d.dcS = {s_q.dcS[0], bus.dataCmd};
      s_d.initS = {s_q.initS[0], bus.chipInitN};
      s_d.busS = {s_q.busS[0], bus.parallelByteBus};
      s_d.wrPrev = s_q.wrS[1];
      s_d.cmdValid = 1'b0;
      s_d.pixValid = 1'b0;
      s_d.initActive = !s_q.initS[1];
      if (!s_q.initS[1])
      begin
        s_d.outOe = 1'b0;
        s_d.cmdByte = '0;
        s_d.pixByte = '0;
      end
      else
      begin
        // Drive only while selected and read strobe low
        s_d.outOe = sel && rdLow && !wrLow;
        if (sel && rdLow)
          s_d.outByte = readByte;
        // Capture on write-strobe rising edge while selected
        if (sel && wrRise)
        begin
          if (s_q.dcS[1])
          begin
            s_d.pixValid = 1'b1;
            s_d.pixByte = s_q.busS[1];
          end
          else
          begin
            s_d.cmdValid = 1'b1;
            s_d.cmdByte = s_q.busS[1];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.csS <= 2'b11;
      s_q.wrS <= 2'b11;
      s_q.rdS <= 2'b11;
      s_q.initS <= 2'b11;
      s_q.wrPrev <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign bus.devByte = s_q.outByte;
  assign bus.devByteOe = s_q.outOe;
  assign cmdValid = s_q.cmdValid;
  assign cmdByte = s_q.cmdByte;
  assign pixValid = s_q.pixValid;
  assign pixByte = s_q.pixByte;
  assign initActive = s_q.initActive;
endmodule // oled_device_port

// ==== verilog/oled_host_port.sv ====
// Host-side end: drives the 8080 parallel port from a register port
// Notes on behaviour
// - Device ignores bus unless selected low
// - Read strobe low while selected drives bus
// - Write strobe low while selected takes byte
// - One 8-bit two-way bus, shared
// - Data/command high means display data
// - Data/command low means command register byte
// - Device initializes while init input low
// - Host ties both mode selects high
// - Command write: fixed pin order sequence
// - Init sends remap and scan commands
// - Init sends com-pins opcode plus parameter
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module oled_host_port
  import oled_port_pkg::*;
#(
  parameter int INIT_PULSE = INIT_PULSE_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  // Parallel bus
  oled_bus_if.host bus
);
  initial
  begin
    if (INIT_PULSE < 1 || INIT_PULSE > 65535)
      $error("oled_host_port: INIT_PULSE out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b010,
    ST_GAP = 3'b110,
    ST_RESET = 3'b111
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [7:0] cnt;
    logic [15:0] pulse;
    logic [2:0] initIdx;
    logic initRun;
    logic initDone;
    logic isRead;
    logic isData;
    logic [7:0] outByte;
    logic oe;
    logic csN;
    logic wrN;
    logic rdN;
    logic dc;
    logic resN;
    logic [7:0] rdByte;
    logic rdValid;
    logic [7:0] rdData;
    logic pendRead;
    logic pendDc;
  } host_reg_t;

  host_reg_t s_q, s_d;
  logic bufInReady, bufOutValid, bufOutReady;
  logic [8:0] bufOutData;
  logic pushReq;
  logic [8:0] pushData;
  logic [7:0] stat;

  function automatic logic [7:0] init_cmd(input logic [2:0] idx);
    case (idx)
      3'd0: init_cmd = CMD_DISPLAY_OFF;
      3'd1: init_cmd = CMD_SEG_REMAP;
      3'd2: init_cmd = CMD_COM_SCAN;
      3'd3: init_cmd = CMD_COM_PINS;
      3'd4: init_cmd = CMD_COM_PINS_ARG;
      default: init_cmd = CMD_DISPLAY_ON;
    endcase
  endfunction

  // Software writes to command/data queue into the buffer, except while init runs or the buffer is full
  assign pushReq = wrStb && (addr == ADDR_CMD || addr == ADDR_DATA);
  assign pushData = {addr == ADDR_DATA, wrData};

  skid_buffer #(.WIDTH(9)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .inValid(pushReq && !s_q.initRun),
    .inReady(bufInReady),
    .inData(pushData),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData)
  );

  assign bufOutReady = (s_q.st == ST_IDLE) && !s_q.initRun && !s_q.pendRead;

  always_comb
  begin
    stat = '0;
    stat[ST_BUSY] = (s_q.st != ST_IDLE) || s_q.initRun || bufOutValid;
    stat[ST_INIT_DONE] = s_q.initDone;
    stat[ST_FULL] = !bufInReady;
    stat[ST_RDVALID] = s_q.rdValid;
  end

  always_comb
  begin
    s_d = s_q;
    if (clkEn)
    begin
      if (rdStb)
        s_d.rdData = (addr == ADDR_STATUS) ? stat :
                     (addr == ADDR_DATA) ? s_q.rdByte : 8'h00;
      if (rdStb && addr == ADDR_DATA)
        s_d.rdValid = 1'b0;
      if (wrStb && addr == ADDR_CTRL)
      begin
        if (wrData[CT_READ])
        begin
          s_d.pendRead = 1'b1;
          s_d.pendDc = wrData[CT_READ_DC];
        end
        if (wrData[CT_START_INIT] && s_q.st == ST_IDLE)
        begin
          s_d.st = ST_RESET;
          s_d.resN = 1'b0;
          s_d.pulse = 16'(INIT_PULSE);
          s_d.initRun = 1'b1;
          s_d.initDone = 1'b0;
          s_d.initIdx = '0;
        end
      end
      case (s_q.st)
        ST_IDLE:
        begin
          if (s_q.initRun)
          begin
            s_d.isRead = 1'b0;
            s_d.isData = 1'b0;
            s_d.outByte = init_cmd(s_q.initIdx);
            s_d.dc = 1'b0;
            s_d.st = ST_SETUP;
            s_d.csN = 1'b0;
            s_d.cnt = 8'(SETUP_CYC);
          end
          else if (s_q.pendRead)
          begin
            if (!(wrStb && addr == ADDR_CTRL && wrData[CT_READ]))
              s_d.pendRead = 1'b0;
            s_d.isRead = 1'b1;
            s_d.dc = s_q.pendDc;
            s_d.csN = 1'b0;
            s_d.st = ST_SETUP;
            s_d.cnt = 8'd1;
          end
          else if (bufOutValid)
          begin
            s_d.isRead = 1'b0;
            s_d.isData = bufOutData[8];
            s_d.outByte = bufOutData[7:0];
            s_d.dc = bufOutData[8];
            s_d.csN = 1'b0;
            s_d.st = ST_SETUP;
            s_d.cnt = 8'd1;
          end
        end
        ST_SETUP:
        begin
          s_d.rdN = !s_q.isRead;
          s_d.wrN = s_q.isRead;
          s_d.oe = !s_q.isRead;
          s_d.st = ST_STROBE;
          s_d.cnt = 8'(s_q.isRead ? RD_STROBE_CYC : CS_LOW_WR_CYC);
        end
        ST_STROBE:
        begin
          if (s_q.cnt > 8'd1)
            s_d.cnt = s_q.cnt - 8'd1;
          else
          begin
            if (s_q.isRead)
            begin
              s_d.rdByte = bus.parallelByteBus;
              s_d.rdValid = 1'b1;
              s_d.rdN = 1'b1;
            end
            else
              s_d.wrN = 1'b1;
            s_d.st = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          s_d.csN = 1'b1;
          s_d.oe = 1'b0;
          s_d.st = ST_GAP;
          s_d.cnt = 8'(CYCLE_MIN_CYC);
        end
        ST_GAP:
        begin
          s_d.dc = 1'b1;
          if (s_q.cnt > 8'd1)
            s_d.cnt = s_q.cnt - 8'd1;
          else
          begin
            s_d.st = ST_IDLE;
            if (s_q.initRun && !s_q.isRead)
            begin
              if (s_q.initIdx == 3'(INIT_LEN - 1))
              begin
                s_d.initRun = 1'b0;
                s_d.initDone = 1'b1;
              end
              else
                s_d.initIdx = s_q.initIdx + 3'd1;
            end
          end
        end
        ST_RESET:
        begin
          if (s_q.pulse > 16'd1)
            s_d.pulse = s_q.pulse - 16'd1;
          else
          begin
            s_d.resN = 1'b1;
            s_d.st = ST_GAP;
            s_d.cnt = 8'(CYCLE_MIN_CYC);
            s_d.initIdx = '0;
            s_d.isRead = 1'b1;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.csN <= 1'b1;
      s_q.wrN <= 1'b1;
      s_q.rdN <= 1'b1;
      s_q.dc <= 1'b1;
      s_q.resN <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign rdData = s_q.rdData;
  assign bus.csN = s_q.csN;
  assign bus.wrN = s_q.wrN;
  assign bus.rdN = s_q.rdN;
  assign bus.dataCmd = s_q.dc;
  assign bus.chipInitN = s_q.resN;
  assign bus.interfaceModeSelA = 1'b1;
  assign bus.interfaceModeSelB = 1'b1;
  assign bus.hostByte = s_q.outByte;
  assign bus.hostByteOe = s_q.oe;
endmodule // oled_host_port

// ==== verilog/oled_port_pkg.sv ====
// Shared constants for the OLED parallel port: timing, commands and register map
package oled_port_pkg;
  localparam int BYTE_W = 8;
  // Clock and bus timing, in ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYCLE_MIN_NS = 300;
  localparam int CS_LOW_WR_NS = 60;
  localparam int CS_LOW_RD_NS = 120;
  localparam int CS_HIGH_NS = 60;
  localparam int DATA_SETUP_NS = 40;
  localparam int ACCESS_MAX_NS = 140;
  // Least times round up to whole cycles
  function automatic int ns_to_cyc(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  localparam int CS_LOW_WR_CYC = ns_to_cyc(CS_LOW_WR_NS);
  localparam int CS_LOW_RD_CYC = ns_to_cyc(CS_LOW_RD_NS);
  localparam int CS_HIGH_CYC = ns_to_cyc(CS_HIGH_NS);
  localparam int SETUP_CYC = ns_to_cyc(DATA_SETUP_NS);
  localparam int CYCLE_MIN_CYC = ns_to_cyc(CYCLE_MIN_NS);
  // Clocks from a read strobe pin edge until the device drives the bus
  localparam int DEV_RD_LAT_CYC = 3;
  // Read strobe also spans the device's pin synchroniser latency
  localparam int RD_STROBE_CYC = CS_LOW_RD_CYC + DEV_RD_LAT_CYC;
  // Initialization pulse length on chip_init_n, in cycles
  localparam int INIT_PULSE_CYC = 100;
  // Command opcodes for the init sequence
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'hae;
  localparam logic [7:0] CMD_SEG_REMAP = 8'ha0;
  localparam logic [7:0] CMD_COM_SCAN = 8'hc8;
  localparam logic [7:0] CMD_COM_PINS = 8'hda;
  localparam logic [7:0] CMD_COM_PINS_ARG = 8'h12;
  localparam logic [7:0] CMD_DISPLAY_ON = 8'haf;
  localparam int INIT_LEN = 6;
  // Host command port register addresses
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_CTRL = 2'h3;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_INIT_DONE = 1;
  localparam int ST_FULL = 2;
  localparam int ST_RDVALID = 3;
  // Control bit positions
  localparam int CT_START_INIT = 0;
  localparam int CT_READ = 1;
  localparam int CT_READ_DC = 2;
endpackage

// ==== verilog/skid_buffer.sv ====
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module skid_buffer #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  initial
  begin
    if (WIDTH < 1) $error("skid_buffer: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rdPtr;
    logic wrPtr;
    logic [1:0] count;
  } buf_state_t;

  buf_state_t s_q, s_d;
  logic doPush, doPop;

  assign inReady = (s_q.count != 2'd2);
  assign outValid = (s_q.count != 2'd0);
  assign outData = s_q.mem[s_q.rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_comb
  begin
    s_d = s_q;
    if (clkEn)
    begin
      if (doPush)
      begin
        s_d.mem[s_q.wrPtr] = inData;
        s_d.wrPtr = ~s_q.wrPtr;
      end
      if (doPop)
        s_d.rdPtr = ~s_q.rdPtr;
      if (doPush && !doPop)
        s_d.count = s_q.count + 2'd1;
      else if (doPop && !doPush)
        s_d.count = s_q.count - 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule // skid_buffer
